/* rtl/pce_engine.sv */
// Serial command engine of the quad volatile digital potentiometer
// How it works
// - Write: control, command, data, each device-acknowledged
// - Commit only after final acknowledge clock
// - Stop or restart mid-byte discards data
// - Back-to-back command/data pairs to volatile locations
// - Read sends high byte, then low byte
// - Read targets last valid command address
// - Pointer survives stop and repeated start
// - Continuous reads while master keeps acknowledging
// - Master not-acknowledge releases data line
// - Invalid command: passive until next start
// - Increment valid only on the four wipers
// - Increment adds one up to full scale
// - Full scale or reserved values stay put
// - Wiper moves right after increment acknowledge
// - Any valid command may follow an increment
// - Over-threshold address pin marks high-voltage sequence
// - Acknowledge command byte only for valid pairs
// - Command byte bit 0 joins data byte as its top bit
`timescale 1ns/1ns
module pce_engine #(
	parameter bit          SEVEN_BIT = 1'b0,                        // 7-bit resistor network
	parameter logic [5:0]  ADDR_HI   = pce_pkg::PCE_SLAVE_ADDR_HI   // Fixed slave address bits
) (
	input  wire logic       mclk,                   // System clock, 100 MHz
	input  wire logic       rst,                    // Power-on or brownout reset
	input  wire logic       scl,                    // Serial clock pin
	input  wire logic       sda_in,                 // Serial data pin level
	output logic            sda_out,                // Serial data drive value
	output logic            sda_oe,                 // Serial data pull-low enable
	input  wire logic       slave_addr_bit_zero,    // Address pin logic level
	input  wire logic       high_voltage_select,    // Address pin above threshold
	output logic            high_voltage_mode,      // Current sequence is high-voltage
	output logic      [8:0] wiper_zero_setting,     // Wiper 0 code
	output logic      [8:0] wiper_one_setting,      // Wiper 1 code
	output logic      [8:0] wiper_two_setting,      // Wiper 2 code
	output logic      [8:0] wiper_three_setting,    // Wiper 3 code
	output logic      [8:0] terminal_control_low,   // Terminal control 0
	output logic      [8:0] terminal_control_high   // Terminal control 1
);
	import pce_pkg::*;

	localparam logic [8:0] FULL_SCALE = SEVEN_BIT ? PCE_FULL_7BIT : PCE_FULL_8BIT;
	localparam logic [8:0] MID_SCALE  = SEVEN_BIT ? PCE_MID_7BIT : PCE_MID_8BIT;

	logic [3:0]  sync_q;
	pce_bus_ev_s ev;
	pce_eng_s    r_reg;
	pce_eng_s    r_next;
	logic [8:0]  rd_val;

	pce_sync u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    ({high_voltage_select, slave_addr_bit_zero, sda_in, scl}),
		.q    (sync_q)
	);

	pce_bus_cond u_cond (
		.mclk  (mclk),
		.rst   (rst),
		.scl_s (sync_q[PCE_SY_SCL]),
		.sda_s (sync_q[PCE_SY_SDA]),
		.ev    (ev)
	);

	// Wiper slot of a wiper address
	function automatic logic [1:0] wiper_slot(input logic [3:0] a);
		case (a)
			PCE_ADR_WIPER1: wiper_slot = 2'h1;
			PCE_ADR_WIPER2: wiper_slot = 2'h2;
			PCE_ADR_WIPER3: wiper_slot = 2'h3;
			default:        wiper_slot = 2'h0;
		endcase
	endfunction : wiper_slot

	function automatic logic is_wiper(input logic [3:0] a);
		is_wiper = (a == PCE_ADR_WIPER0) || (a == PCE_ADR_WIPER1) ||
		           (a == PCE_ADR_WIPER2) || (a == PCE_ADR_WIPER3);
	endfunction : is_wiper

	function automatic logic is_volatile(input logic [3:0] a);
		is_volatile = is_wiper(a) || (a == PCE_ADR_TCON0) || (a == PCE_ADR_TCON1);
	endfunction : is_volatile

	function automatic logic cmd_valid(input logic [3:0] a, input logic [1:0] c);
		case (c)
			PCE_CMD_WRITE: cmd_valid = is_volatile(a);
			PCE_CMD_READ:  cmd_valid = is_volatile(a) || (a == PCE_ADR_STATUS);
			PCE_CMD_INC:   cmd_valid = is_wiper(a);
			default:       cmd_valid = 1'b0;
		endcase
	endfunction : cmd_valid

	// Value seen by a read of a location
	function automatic logic [8:0] loc_value(input pce_eng_s s, input logic [3:0] a);
		if (is_wiper(a)) begin
			loc_value = s.wiper[wiper_slot(a)];
		end else if (a == PCE_ADR_TCON0) begin
			loc_value = s.terminal_control[0];
		end else if (a == PCE_ADR_TCON1) begin
			loc_value = s.terminal_control[1];
		end else begin
			loc_value = PCE_STATUS_RD;
		end
	endfunction : loc_value

	function automatic logic [8:0] sat_inc(input logic [8:0] v);
		if (v < FULL_SCALE) begin
			sat_inc = v + 9'h001;
		end else begin
			sat_inc = v;
		end
	endfunction : sat_inc

	// Location under the read pointer
	assign rd_val = loc_value(r_reg, r_reg.ptr);

	always_comb begin
		r_next = r_reg;
		if (ev.start) begin
			// only a start revives the engine
			r_next.state = PCE_RECV;
			r_next.phase = PCE_PH_CTRL;
			r_next.cnt = 4'h0;
			r_next.sda_oe = 1'b0;
			r_next.hv_mode = sync_q[PCE_SY_HV];
		end else if (ev.stop) begin
			r_next.state = PCE_IDLE;
			r_next.cnt = 4'h0;
			r_next.sda_oe = 1'b0;
			r_next.hv_mode = 1'b0;
		end else begin
			case (r_reg.state)
				PCE_IDLE: begin
					r_next.sda_oe = 1'b0;
				end
				PCE_RECV: begin
					if (ev.scl_rise && r_reg.cnt != PCE_BYTE_BITS) begin
						r_next.shreg = {r_reg.shreg[6:0], ev.sda};
						r_next.cnt = r_reg.cnt + 4'h1;
					end else if (ev.scl_fall && r_reg.cnt == PCE_BYTE_BITS) begin
						r_next.cnt = 4'h0;
						case (r_reg.phase)
							PCE_PH_CTRL: begin
								r_next.ack_ok = (r_reg.shreg[7:1] ==
								                 {ADDR_HI, sync_q[PCE_SY_A0]});
								r_next.read_dir = r_reg.shreg[0];
							end
							PCE_PH_CMD: begin
								r_next.cmd_addr = r_reg.shreg[PCE_CB_ADDR_MSB:PCE_CB_ADDR_LSB];
								r_next.cmd_op = r_reg.shreg[PCE_CB_CMD_MSB:PCE_CB_CMD_LSB];
								r_next.cmd_dmsb = r_reg.shreg[PCE_CB_DMSB];
								r_next.ack_ok = cmd_valid(
									r_reg.shreg[PCE_CB_ADDR_MSB:PCE_CB_ADDR_LSB],
									r_reg.shreg[PCE_CB_CMD_MSB:PCE_CB_CMD_LSB]);
							end
							default: begin
								r_next.ack_ok = 1'b1;
							end
						endcase
						r_next.sda_oe = r_next.ack_ok;
						r_next.state = PCE_ACK;
						if (r_reg.phase == PCE_PH_CTRL &&
						    r_reg.shreg[7:1] != {ADDR_HI, sync_q[PCE_SY_A0]}) begin
							r_next.sda_oe = 1'b0;
							r_next.state = PCE_IDLE;
						end else if (r_reg.phase == PCE_PH_CMD &&
						             !cmd_valid(
						                 r_reg.shreg[PCE_CB_ADDR_MSB:PCE_CB_ADDR_LSB],
						                 r_reg.shreg[PCE_CB_CMD_MSB:PCE_CB_CMD_LSB])) begin
							r_next.sda_oe = 1'b0;
							r_next.state = PCE_IDLE;
						end
					end
				end
				PCE_ACK: begin
					if (ev.scl_fall) begin
						r_next.sda_oe = 1'b0;
						r_next.state = PCE_RECV;
						case (r_reg.phase)
							PCE_PH_CTRL: begin
								if (r_reg.read_dir) begin
									r_next.txbyte = {7'h00, rd_val[8]};
									r_next.low_next = 1'b1;
									// Drive the top bit of the byte first
									r_next.sda_oe = ~r_next.txbyte[7];
									r_next.state = PCE_SEND;
								end else begin
									r_next.phase = PCE_PH_CMD;
								end
							end
							PCE_PH_CMD: begin
								r_next.ptr = r_reg.cmd_addr;
								if (r_reg.cmd_op == PCE_CMD_WRITE) begin
									r_next.phase = PCE_PH_DATA;
								end else if (r_reg.cmd_op == PCE_CMD_INC) begin
									r_next.wiper[wiper_slot(r_reg.cmd_addr)] =
										sat_inc(r_reg.wiper[wiper_slot(r_reg.cmd_addr)]);
								end
							end
							default: begin
								// join top bit and data byte
								if (is_wiper(r_reg.cmd_addr)) begin
									r_next.wiper[wiper_slot(r_reg.cmd_addr)] =
										{r_reg.cmd_dmsb, r_reg.shreg};
								end else if (r_reg.cmd_addr == PCE_ADR_TCON0) begin
									r_next.terminal_control[0] = {r_reg.cmd_dmsb, r_reg.shreg};
								end else begin
									r_next.terminal_control[1] = {r_reg.cmd_dmsb, r_reg.shreg};
								end
								r_next.phase = PCE_PH_CMD;
							end
						endcase
					end
				end
				PCE_SEND: begin
					if (ev.scl_fall) begin
						if (r_reg.cnt == PCE_LAST_BIT) begin
							r_next.cnt = 4'h0;
							r_next.sda_oe = 1'b0;
							r_next.state = PCE_MACK;
						end else begin
							r_next.cnt = r_reg.cnt + 4'h1;
							r_next.txbyte = {r_reg.txbyte[6:0], 1'b0};
							r_next.sda_oe = ~r_reg.txbyte[6];
						end
					end
				end
				PCE_MACK: begin
					if (ev.scl_rise) begin
						r_next.master_ack = ~ev.sda;
					end else if (ev.scl_fall) begin
						if (r_reg.master_ack) begin
							if (r_reg.low_next) begin
								r_next.txbyte = rd_val[7:0];
							end else begin
								r_next.txbyte = {7'h00, rd_val[8]};
							end
							r_next.sda_oe = ~r_next.txbyte[7];
							r_next.low_next = ~r_reg.low_next;
							r_next.state = PCE_SEND;
						end else begin
							r_next.sda_oe = 1'b0;
							r_next.state = PCE_IDLE;
						end
					end
				end
				default: begin
					r_next.state = PCE_IDLE;
					r_next.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r_reg <= '0;
			r_reg.wiper <= {4{MID_SCALE}};
			r_reg.terminal_control <= {2{PCE_TERMINAL_CONTROL_RST}};
			r_reg.ptr <= PCE_PTR_RST;
			r_reg.state <= PCE_IDLE;
			r_reg.phase <= PCE_PH_CTRL;
		end else begin
			r_reg <= r_next;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = r_reg.sda_oe;
	assign high_voltage_mode = r_reg.hv_mode;
	assign wiper_zero_setting = r_reg.wiper[0];
	assign wiper_one_setting = r_reg.wiper[1];
	assign wiper_two_setting = r_reg.wiper[2];
	assign wiper_three_setting = r_reg.wiper[3];
	assign terminal_control_low = r_reg.terminal_control[0];
	assign terminal_control_high = r_reg.terminal_control[1];

endmodule : pce_engine

/* rtl/pce_pkg.sv */
// Shared constants, types and state records of the pot command engine
package pce_pkg;

	// Location addresses
	localparam logic [3:0] PCE_ADR_WIPER0 = 4'h0;
	localparam logic [3:0] PCE_ADR_WIPER1 = 4'h1;
	localparam logic [3:0] PCE_ADR_TCON0  = 4'h4;
	localparam logic [3:0] PCE_ADR_STATUS = 4'h5;
	localparam logic [3:0] PCE_ADR_WIPER2 = 4'h6;
	localparam logic [3:0] PCE_ADR_WIPER3 = 4'h7;
	localparam logic [3:0] PCE_ADR_TCON1  = 4'hA;

	// Command field codes
	localparam logic [1:0] PCE_CMD_WRITE = 2'h0;
	localparam logic [1:0] PCE_CMD_INC   = 2'h1;
	localparam logic [1:0] PCE_CMD_DEC   = 2'h2;
	localparam logic [1:0] PCE_CMD_READ  = 2'h3;

	// Command byte field positions
	localparam int PCE_CB_ADDR_MSB = 7;
	localparam int PCE_CB_ADDR_LSB = 4;
	localparam int PCE_CB_CMD_MSB  = 3;
	localparam int PCE_CB_CMD_LSB  = 2;
	localparam int PCE_CB_DMSB     = 0;

	// Scale points and values after reset
	localparam logic [8:0] PCE_FULL_8BIT = 9'h100;
	localparam logic [8:0] PCE_FULL_7BIT = 9'h080;
	localparam logic [8:0] PCE_MID_8BIT  = 9'h080;
	localparam logic [8:0] PCE_MID_7BIT  = 9'h040;
	localparam logic [8:0] PCE_TERMINAL_CONTROL_RST  = 9'h1FF;
	localparam logic [3:0] PCE_PTR_RST   = 4'h0;
	localparam logic [8:0] PCE_STATUS_RD = 9'h000;

	// Upper six bits of the slave address (value arbitrary)
	localparam logic [5:0] PCE_SLAVE_ADDR_HI = 6'h2A;

	// Bits per byte, counted up to the last one
	localparam logic [3:0] PCE_LAST_BIT = 4'h7;
	localparam logic [3:0] PCE_BYTE_BITS = 4'h8;

	// Order of the synchronised inputs
	localparam int PCE_SY_SCL = 0;
	localparam int PCE_SY_SDA = 1;
	localparam int PCE_SY_A0  = 2;
	localparam int PCE_SY_HV  = 3;

	typedef enum logic [2:0] {
		PCE_IDLE,
		PCE_RECV,
		PCE_ACK,
		PCE_SEND,
		PCE_MACK
	} pce_state_e;

	typedef enum logic [1:0] {
		PCE_PH_CTRL,
		PCE_PH_CMD,
		PCE_PH_DATA
	} pce_phase_e;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
	} pce_sync_s;

	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} pce_bus_ev_s;

	typedef struct packed {
		logic        scl_d;
		logic        sda_d;
		pce_bus_ev_s ev;
	} pce_cond_s;

	typedef struct packed {
		logic [3:0][8:0] wiper;
		logic [1:0][8:0] terminal_control;
		pce_state_e      state;
		pce_phase_e      phase;
		logic [3:0]      cnt;
		logic [7:0]      shreg;
		logic [7:0]      txbyte;
		logic [3:0]      ptr;
		logic [3:0]      cmd_addr;
		logic [1:0]      cmd_op;
		logic            cmd_dmsb;
		logic            ack_ok;
		logic            read_dir;
		logic            low_next;
		logic            master_ack;
		logic            sda_oe;
		logic            hv_mode;
	} pce_eng_s;

endpackage : pce_pkg

/* rtl/pce_sync.sv */
// Two-flop synchroniser for the bus pins and address strap
`timescale 1ns/1ns
module pce_sync (
	input  wire logic       mclk,   // System clock
	input  wire logic       rst,    // Synchronous reset
	input  wire logic [3:0] d,      // Asynchronous inputs
	output logic      [3:0] q       // Synchronised inputs
);
	import pce_pkg::*;

	pce_sync_s r_reg;
	pce_sync_s r_next;

	always_comb begin
		r_next = r_reg;
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
	end

	// Idle bus level is high on both lines
	always_ff @(posedge mclk) begin
		if (rst) begin
			r_reg <= '{s1: 4'h3, s2: 4'h3};
		end else begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.s2;

endmodule : pce_sync

/* rtl/pce_bus_cond.sv */
// Edge, start and stop detection on synchronised SCL and SDA
`timescale 1ns/1ns
module pce_bus_cond (
	input  wire logic   mclk,   // System clock
	input  wire logic   rst,    // Synchronous reset
	input  wire logic   scl_s,  // Synchronised clock line
	input  wire logic   sda_s,  // Synchronised data line
	output pce_pkg::pce_bus_ev_s ev  // Registered bus events
);
	import pce_pkg::*;

	pce_cond_s r_reg;
	pce_cond_s r_next;

	always_comb begin
		r_next = r_reg;
		r_next.scl_d = scl_s;
		r_next.sda_d = sda_s;
		r_next.ev.sda = sda_s;
		r_next.ev.scl_rise = scl_s & ~r_reg.scl_d;
		r_next.ev.scl_fall = ~scl_s & r_reg.scl_d;
		// Data moves while the clock stays high
		r_next.ev.start = scl_s & r_reg.scl_d & r_reg.sda_d & ~sda_s;
		r_next.ev.stop = scl_s & r_reg.scl_d & ~r_reg.sda_d & sda_s;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r_reg <= '{scl_d: 1'b1, sda_d: 1'b1, ev: '{default: 1'b0}};
		end else begin
			r_reg <= r_next;
		end
	end

	assign ev = r_reg.ev;

endmodule : pce_bus_cond

/* tb/pce_master.sv */
// Serial bus master model driving the engine
`timescale 1ns/1ns
module pce_master (
	output logic      scl,    // Serial clock
	output logic      sda_lo, // Pull data low
	input  wire logic sda     // Resolved data line
);
	initial begin
		scl = 1'b1;
		sda_lo = 1'b0;
	end
	task automatic bitw(input logic b);
		sda_lo = !b;
		#31 scl = 1'b1;
		#62 scl = 1'b0;
		#32;
	endtask : bitw
	task automatic rbit(output logic b);
		sda_lo = 1'b0;
		#31 scl = 1'b1;
		#31 b = sda;
		#31 scl = 1'b0;
		#32;
	endtask : rbit
	task automatic start();
		sda_lo = 1'b0;
		#31 scl = 1'b1;
		#62 sda_lo = 1'b1;
		#62 scl = 1'b0;
		#32;
	endtask : start
	task automatic stop();
		sda_lo = 1'b1;
		#31 scl = 1'b1;
		#62 sda_lo = 1'b0;
		#62;
	endtask : stop
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) bitw(d[i]);
		rbit(b);
		ack = !b;
	endtask : wbyte
	// master acks to go on, nacks to end
	task automatic rbyte(input logic ack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) rbit(d[i]);
		bitw(!ack);
	endtask : rbyte
endmodule : pce_master

/* tb/pce_engine_chk.sv */
// Port assertions for the pot command engine
`timescale 1ns/1ns
module pce_engine_chk #(
	parameter bit SEVEN_BIT = 1'b0 // 7-bit network
) (
	input wire logic       mclk,                  // System clock
	input wire logic       rst,                   // Reset
	input wire logic       scl,                   // Serial clock
	input wire logic       sda_in,                // Data line
	input wire logic       sda_oe,                // Data pull-low
	input wire logic       high_voltage_mode,     // Sequence mode
	input wire logic [8:0] wiper_zero_setting,    // Wiper 0
	input wire logic [8:0] wiper_one_setting,     // Wiper 1
	input wire logic [8:0] wiper_two_setting,     // Wiper 2
	input wire logic [8:0] wiper_three_setting,   // Wiper 3
	input wire logic [8:0] terminal_control_low,  // Terminal 0
	input wire logic [8:0] terminal_control_high  // Terminal 1
);
	import pce_pkg::*;
	localparam logic [8:0] MID = SEVEN_BIT ? PCE_MID_7BIT : PCE_MID_8BIT;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_reset_values: assert property (disable iff (1'b0) $fell(rst) |->
		wiper_zero_setting == MID && wiper_three_setting == MID
		&& terminal_control_low == PCE_TERMINAL_CONTROL_RST && !sda_oe && !high_voltage_mode)
		else $error("values after reset wrong");
	a_wiper_hold: assert property (!$stable({wiper_zero_setting, wiper_one_setting,
		wiper_two_setting, wiper_three_setting}) |-> !scl)
		else $error("wiper changed while clock high");
	a_terminal_control_hold: assert property (!$stable({terminal_control_low,
		terminal_control_high}) |-> !scl)
		else $error("terminal control changed while clock high");
	a_one_target: assert property ($countones({!$stable(wiper_zero_setting),
		!$stable(wiper_one_setting), !$stable(wiper_two_setting),
		!$stable(wiper_three_setting)}) <= 1)
		else $error("two wipers changed at once");
	a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl)
		else $error("data drive began with clock high");
	a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl)
		else $error("data release with clock high");
	a_oe_stands: assert property ($rose(sda_oe) |-> sda_oe[*8])
		else $error("data drive too short");
	a_hv_at_start: assert property ($rose(high_voltage_mode) |-> scl && !sda_in)
		else $error("mode set outside start");
	a_hv_at_stop: assert property ($fell(high_voltage_mode) |-> scl && sda_in)
		else $error("mode cleared outside stop");
endmodule : pce_engine_chk
bind pce_engine pce_engine_chk #(.SEVEN_BIT(SEVEN_BIT)) u_chk (
	.mclk, .rst, .scl, .sda_in, .sda_oe, .high_voltage_mode,
	.wiper_zero_setting, .wiper_one_setting, .wiper_two_setting,
	.wiper_three_setting, .terminal_control_low, .terminal_control_high);

/* tb/tb_top.sv */
// Self-checking bench for the pot command engine
`timescale 1ns/1ns
module tb_top;
	import pce_pkg::*;
	logic       mclk, rst, a0, hv, sda_oe, hv_mode, scl, sda_lo, ack;
	logic [8:0] w0, w1, w2, w3, tc0, tc1;
	logic       sda_drv;
	logic [8:0] e [16];
	logic [3:0] ptr, k;
	logic [3:0] wl [6] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'hA};
	int         failures, tests_run, cycles;
	int         seed = 32'h8e366090;
	wire        sda = (sda_oe ? sda_drv : 1'b1) && !sda_lo;
	pce_engine dut (.mclk, .rst, .scl, .sda_in(sda), .sda_out(sda_drv), .sda_oe,
		.slave_addr_bit_zero(a0), .high_voltage_select(hv), .high_voltage_mode(hv_mode),
		.wiper_zero_setting(w0), .wiper_one_setting(w1), .wiper_two_setting(w2),
		.wiper_three_setting(w3), .terminal_control_low(tc0), .terminal_control_high(tc1));
	pce_master m (.scl, .sda_lo, .sda);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = !mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			$display("[FAIL] %0t timeout", $time);
			stop_test();
		end
	end
	function automatic logic [8:0] inc_f(input logic [8:0] v);
		return (v < PCE_FULL_8BIT) ? v + 9'h001 : v;
	endfunction : inc_f
	task automatic ck(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : ck
	task automatic ck_regs();
		logic [8:0] g [6];
		g = '{w0, w1, tc0, w2, w3, tc1};
		foreach (g[i]) ck({7'h0, g[i]}, {7'h0, e[wl[i]]});
	endtask : ck_regs
	task automatic open(input logic rw, input logic good);
		m.start();
		m.wbyte({PCE_SLAVE_ADDR_HI ^ {5'h0, !good}, a0, rw}, ack);
		ck({15'h0, ack}, {15'h0, good});
	endtask : open
	task automatic cmd(input logic [3:0] a, input logic [1:0] op, input logic [8:0] v,
		input logic good);
		m.wbyte({a, op, 1'b0, v[8]}, ack);
		ck({15'h0, ack}, {15'h0, good});
		if (good) ptr = a;
		if (op == PCE_CMD_WRITE) begin
			m.wbyte(v[7:0], ack);
			ck({15'h0, ack}, {15'h0, good});
			if (good) e[a] = v;
		end
		if (good && op == PCE_CMD_INC) begin
			e[a] = inc_f(e[a]);
			#30 ck_regs();
		end
	endtask : cmd
	task automatic rd(input logic [3:0] a, input logic use_cmd, input int n);
		logic [7:0] hi, lo;
		if (use_cmd) begin
			open(1'b0, 1'b1);
			cmd(a, PCE_CMD_READ, 9'h000, 1'b1);
		end
		open(1'b1, 1'b1);
		for (int i = 0; i < n; i++) begin
			m.rbyte(1'b1, hi);
			m.rbyte(i < n - 1, lo);
			ck({hi, lo}, {7'h0, e[ptr]});
		end
		m.stop();
	endtask : rd
	task automatic reset_dut();
		@(negedge mclk) rst = 1'b1;
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		foreach (e[i]) e[i] = 9'h000;
		foreach (wl[i]) e[wl[i]] = PCE_MID_8BIT;
		e[4] = PCE_TERMINAL_CONTROL_RST;
		e[10] = PCE_TERMINAL_CONTROL_RST;
		ptr = PCE_PTR_RST;
		repeat (6) @(negedge mclk);
	endtask : reset_dut
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		rst = 1'b1;
		a0 = 1'b0;
		hv = 1'b0;
		reset_dut();
		ck_regs();
		rd(4'h0, 1'b0, 1);
		open(1'b0, 1'b0);
		m.stop();
		for (int i = 0; i < 12; i++) begin
			@(negedge mclk) a0 = 1'($random(seed));
			open(1'b0, 1'b1);
			k = wl[$unsigned($random(seed)) % 6];
			cmd(k, PCE_CMD_WRITE, 9'($random(seed)), 1'b1);
			k = wl[$unsigned($random(seed)) % 6];
			cmd(k, PCE_CMD_WRITE, 9'($random(seed)), 1'b1);
			m.stop();
			ck_regs();
			rd(4'h0, 1'b0, 3);
		end
		foreach (wl[i]) rd(wl[i], 1'b1, 1);
		rd(PCE_ADR_STATUS, 1'b1, 2);
		open(1'b0, 1'b1);
		cmd(4'h0, PCE_CMD_WRITE, 9'h0FF, 1'b1);
		cmd(4'h0, PCE_CMD_INC, 9'h000, 1'b1);
		cmd(4'h0, PCE_CMD_INC, 9'h000, 1'b1);
		cmd(4'h6, PCE_CMD_WRITE, 9'h1F0, 1'b1);
		cmd(4'h6, PCE_CMD_INC, 9'h000, 1'b1);
		cmd(4'h7, PCE_CMD_INC, 9'h000, 1'b1);
		cmd(4'h1, PCE_CMD_INC, 9'h000, 1'b1);
		cmd(4'h4, PCE_CMD_WRITE, 9'h0A5, 1'b1);
		m.stop();
		ck_regs();
		open(1'b0, 1'b1);
		cmd(4'h4, PCE_CMD_INC, 9'h000, 1'b0);
		cmd(4'h0, PCE_CMD_WRITE, 9'h055, 1'b0);
		m.stop();
		open(1'b0, 1'b1);
		cmd(4'h1, PCE_CMD_DEC, 9'h000, 1'b0);
		m.stop();
		open(1'b0, 1'b1);
		cmd(4'h2, PCE_CMD_WRITE, 9'h033, 1'b0);
		m.start();
		open(1'b0, 1'b1);
		cmd(4'h9, PCE_CMD_READ, 9'h000, 1'b0);
		m.stop();
		open(1'b0, 1'b1);
		m.wbyte(8'h10, ack);
		ptr = 4'h1;
		for (int i = 0; i < 4; i++) m.bitw(1'b0);
		m.stop();
		ck_regs();
		rd(4'h0, 1'b0, 1);
		@(negedge mclk) begin
			hv = 1'b1;
			a0 = 1'b1;
		end
		#500;
		open(1'b0, 1'b1);
		ck({15'h0, hv_mode}, 16'h0001);
		cmd(4'h1, PCE_CMD_WRITE, 9'h1AA, 1'b1);
		m.stop();
		#100 ck({15'h0, hv_mode}, 16'h0000);
		@(negedge mclk) hv = 1'b0;
		ck_regs();
		reset_dut();
		ck_regs();
		rd(4'h0, 1'b0, 1);
		stop_test();
	end
endmodule : tb_top
